// >>> logic/isaseq_pkg.sv
package isaseq_pkg;

  // spacing figures in bus clock periods
  localparam logic [4:0] ISASEQ_ALE_TO_CMD      = 5'h02;
  localparam logic [4:0] ISASEQ_ALE_TO_CMD_NEG  = 5'h0B;
  localparam logic [4:0] ISASEQ_ALE_NEG_TO_LA   = 5'h0E;
  localparam logic [4:0] ISASEQ_CMD_TO_LA       = 5'h0D;
  localparam logic [4:0] ISASEQ_CMD_WIDTH       = 5'h09;
  localparam logic [4:0] ISASEQ_CMD_TO_SA_MEM   = 5'h0A;
  localparam logic [4:0] ISASEQ_CMD_TO_SA_IO    = 5'h13;
  localparam logic [4:0] ISASEQ_CMD_TO_ALE      = 5'h0A;
  localparam logic [4:0] ISASEQ_CMD_TO_CMD      = 5'h0C;
  localparam logic [4:0] ISASEQ_NEG_TO_CMD      = 5'h03;
  localparam logic [4:0] ISASEQ_NEG_TO_ALE      = 5'h01;
  localparam logic [4:0] ISASEQ_RDY_FROM_LA_16  = 5'h08;
  localparam logic [4:0] ISASEQ_RDY_FROM_LA_8   = 5'h0E;
  localparam logic [4:0] ISASEQ_RDY_FROM_ALE_16 = 5'h06;
  localparam logic [4:0] ISASEQ_RDY_FROM_ALE_8  = 5'h0C;
  localparam logic [4:0] ISASEQ_DATA_FROM_ALE_16 = 5'h04;
  localparam logic [4:0] ISASEQ_DATA_FROM_ALE_8  = 5'h0A;
  localparam logic [4:0] ISASEQ_DATA_FROM_LA_16 = 5'h08;
  localparam logic [4:0] ISASEQ_DATA_FROM_LA_8  = 5'h0E;
  localparam logic [4:0] ISASEQ_ALE_WIDTH       = 5'h01;
  localparam logic [4:0] ISASEQ_ZERO            = 5'h00;
  localparam logic [4:0] ISASEQ_ONE             = 5'h01;

  // command class of an access
  typedef enum logic [1:0] {
    ISASEQ_MEM,
    ISASEQ_SMEM,
    ISASEQ_IO
  } isaseq_class_e;

  typedef enum logic [2:0] {
    ISASEQ_IDLE,
    ISASEQ_ALE,
    ISASEQ_SETUP,
    ISASEQ_CMD,
    ISASEQ_WAIT,
    ISASEQ_HOLD
  } isaseq_state_e;

endpackage : isaseq_pkg

// >>> logic/isaseq_master.sv
// Operation
// - latch strobe leads a memory command by at least 2 bus clocks
// - latch strobe leads a system-memory command by at least 2 bus clocks
// - latch strobe leads an I/O command by at least 2 bus clocks
// - at least 11 bus clocks from latch strobe to memory command negation
// - latched upper address held 14 bus clocks after latch strobe negation
// - latched upper address held 13 bus clocks after memory command
// - memory command asserted at least 9 bus clocks
// - system-memory command asserted at least 9 bus clocks
// - I/O command asserted at least 9 bus clocks
// - system address held 10 (memory) or 19 (I/O) clocks after command
// - at least 10 bus clocks from command to next latch strobe
// - same-class commands start at least 12 bus clocks apart
// - at least 3 bus clocks from command negation to next command
// - at least 1 bus clock from command negation to next latch strobe
// - ready not sampled before 8/14 clocks after latched address valid
// - ready not sampled before 6/12 clocks after latch strobe
// - ready not sampled before 6/12 clocks after system address valid
// - read data captured no earlier than 8/14 clocks after latched address
// - read data captured no earlier than 4/10 clocks after latch strobe
`timescale 1ns/1ns
module isaseq_master (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_b,
  // isa bus clock, sampled
  input  wire logic                   bus_clk,
  // internal request side
  input  wire logic                   req_valid,
  input  wire logic                   req_write,
  input  wire logic                   req_is16,
  input  wire isaseq_pkg::isaseq_class_e req_class,
  input  wire logic [23:0]            req_addr,
  input  wire logic [15:0]            req_wdata,
  output logic                        req_ready,
  output logic                        rsp_valid,
  output logic [15:0]                 rsp_rdata,
  // isa bus side
  output logic                        ale,
  output logic [23:17]                la,
  output logic                        la_oe_b,
  output logic [19:0]                 sa,
  output logic                        sa_oe_b,
  output logic                        memr_b,
  output logic                        memw_b,
  output logic                        smemr_b,
  output logic                        smemw_b,
  output logic                        ior_b,
  output logic                        iow_b,
  output logic [15:0]                 sd_out,
  output logic                        sd_oe_b,
  input  wire logic [15:0]            sd_in,
  input  wire logic                   iochrdy
);
  import isaseq_pkg::*;

  // two-flop synchronisers on everything from the bus pins
  logic        bclk_s1;
  logic        bclk_s2;
  logic        bclk_s3;
  logic        rdy_s1;
  logic        rdy_s2;
  logic [15:0] sd_s1;
  logic [15:0] sd_s2;
  logic        tick;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bclk_s1 <= 1'b0;
      bclk_s2 <= 1'b0;
      bclk_s3 <= 1'b0;
      rdy_s1  <= 1'b1;
      rdy_s2  <= 1'b1;
      sd_s1   <= 16'h0000;
      sd_s2   <= 16'h0000;
    end else begin
      bclk_s1 <= bus_clk;
      bclk_s2 <= bclk_s1;
      bclk_s3 <= bclk_s2;
      rdy_s1  <= iochrdy;
      rdy_s2  <= rdy_s1;
      sd_s1   <= sd_in;
      sd_s2   <= sd_s1;
    end
  end

  // one bus clock period elapses at each rising edge
  assign tick = bclk_s2 & ~bclk_s3;

  isaseq_state_e state;
  isaseq_class_e cls;
  logic          wr;
  logic          w16;
  logic [4:0]    phase_cnt;  // clocks in the current phase
  logic [4:0]    ale_cnt;    // clocks since latch strobe asserted
  logic [4:0]    cmd_cnt;    // clocks since command asserted
  logic [4:0]    neg_cnt;    // clocks since command negated
  logic [4:0]    prev_cmd;   // clocks since last command start
  logic [4:0]    la_hold;    // clocks of upper address hold left
  logic [4:0]    sa_hold;    // clocks of system address hold left
  logic          first;
  logic          cmd_on;
  logic [4:0]    rdy_min;
  logic [4:0]    data_min;
  logic [4:0]    sa_min;
  logic          cmd_ok;
  logic          ale_ok;
  logic          done_ok;

  // earliest ready sample and data capture, counted from the strobe;
  // the latched address is already valid at the strobe, so its figures
  // (8/14) are used directly, and they also cover the smaller strobe-based ones
  always_comb begin
    if (w16) begin
      rdy_min  = ISASEQ_RDY_FROM_LA_16;
      data_min = ISASEQ_DATA_FROM_LA_16;
    end else begin
      rdy_min  = ISASEQ_RDY_FROM_LA_8;
      data_min = ISASEQ_DATA_FROM_LA_8;
    end
    if (cls == ISASEQ_IO) begin
      sa_min = ISASEQ_CMD_TO_SA_IO;
    end else begin
      sa_min = ISASEQ_CMD_TO_SA_MEM;
    end
  end

  // ale_cnt too: strobe and system address start
  // together, and the LA-based figures are the larger ones
  assign cmd_ok  = (phase_cnt >= ISASEQ_ALE_TO_CMD)
                 & (first | (neg_cnt >= ISASEQ_NEG_TO_CMD))
                 & (first | (prev_cmd >= ISASEQ_CMD_TO_CMD));
  assign ale_ok  = (neg_cnt >= ISASEQ_NEG_TO_ALE)
                 & (first | (prev_cmd >= ISASEQ_CMD_TO_ALE));
  assign done_ok = (cmd_cnt >= ISASEQ_CMD_WIDTH)
                 & (ale_cnt >= ISASEQ_ALE_TO_CMD_NEG)
                 & (ale_cnt >= rdy_min)
                 & (ale_cnt >= data_min)
                 & rdy_s2;

  // sequencer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state     <= ISASEQ_IDLE;
      cls       <= ISASEQ_MEM;
      wr        <= 1'b0;
      w16       <= 1'b0;
      phase_cnt <= ISASEQ_ZERO;
      cmd_on    <= 1'b0;
      first     <= 1'b1;
      ale       <= 1'b0;
      la        <= 7'h00;
      sa        <= 20'h0_0000;
      sd_out    <= 16'h0000;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= 16'h0000;
    end else begin
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      case (state)
        ISASEQ_IDLE: begin
          if (req_valid && tick && ale_ok) begin
            cls       <= req_class;
            wr        <= req_write;
            w16       <= req_is16;
            la        <= req_addr[23:17];
            sa        <= req_addr[19:0];
            sd_out    <= req_wdata;
            req_ready <= 1'b1;
            ale       <= 1'b1;
            phase_cnt <= ISASEQ_ZERO;
            state     <= ISASEQ_ALE;
          end
        end
        ISASEQ_ALE: begin
          if (tick) begin
            ale       <= 1'b0;
            phase_cnt <= ISASEQ_ALE_WIDTH;
            state     <= ISASEQ_SETUP;
          end
        end
        ISASEQ_SETUP: begin
          if (tick) begin
            phase_cnt <= phase_cnt + ISASEQ_ONE;
            if (cmd_ok) begin
              cmd_on <= 1'b1;
              first  <= 1'b0;
              state  <= ISASEQ_CMD;
            end
          end
        end
        ISASEQ_CMD: begin
          if (tick && done_ok) begin
            if (!wr) begin
              rsp_rdata <= sd_s2;
            end
            rsp_valid <= 1'b1;
            cmd_on    <= 1'b0;
            state     <= ISASEQ_HOLD;
          end
        end
        default: begin
          // hold addresses until both hold windows have run out
          if (la_hold == ISASEQ_ZERO && sa_hold == ISASEQ_ZERO) begin
            state <= ISASEQ_IDLE;
          end
        end
      endcase
    end
  end

  // phase counters, reloaded at strobe and command edges
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ale_cnt  <= ISASEQ_ZERO;
      cmd_cnt  <= ISASEQ_ZERO;
      neg_cnt  <= ISASEQ_CMD_TO_CMD;
      prev_cmd <= ISASEQ_CMD_TO_CMD;
    end else if (tick) begin
      if (state == ISASEQ_IDLE && req_valid && ale_ok) begin
        ale_cnt <= ISASEQ_ZERO;
      end else if (ale_cnt != 5'h1F) begin
        ale_cnt <= ale_cnt + ISASEQ_ONE;
      end
      if (state == ISASEQ_SETUP && cmd_ok) begin
        cmd_cnt  <= ISASEQ_ZERO;
        prev_cmd <= ISASEQ_ZERO;
      end else begin
        if (cmd_cnt != 5'h1F) begin
          cmd_cnt <= cmd_cnt + ISASEQ_ONE;
        end
        if (prev_cmd != 5'h1F) begin
          prev_cmd <= prev_cmd + ISASEQ_ONE;
        end
      end
      if (state == ISASEQ_CMD && done_ok) begin
        neg_cnt <= ISASEQ_ZERO;
      end else if (!cmd_on && neg_cnt != 5'h1F) begin
        neg_cnt <= neg_cnt + ISASEQ_ONE;
      end
    end
  end

  // address hold windows
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      la_hold <= ISASEQ_ZERO;
      sa_hold <= ISASEQ_ZERO;
    end else if (tick) begin
      if (state == ISASEQ_ALE) begin
        la_hold <= ISASEQ_ALE_NEG_TO_LA;
      end else if (state == ISASEQ_SETUP && cmd_ok) begin
        if (la_hold < ISASEQ_CMD_TO_LA) begin
          la_hold <= ISASEQ_CMD_TO_LA;
        end else begin
          la_hold <= la_hold - ISASEQ_ONE;
        end
        sa_hold <= sa_min;
      end else begin
        if (la_hold != ISASEQ_ZERO) begin
          la_hold <= la_hold - ISASEQ_ONE;
        end
        if (sa_hold != ISASEQ_ZERO) begin
          sa_hold <= sa_hold - ISASEQ_ONE;
        end
      end
    end
  end

  // pin drivers, all registered
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      memr_b  <= 1'b1;
      memw_b  <= 1'b1;
      smemr_b <= 1'b1;
      smemw_b <= 1'b1;
      ior_b   <= 1'b1;
      iow_b   <= 1'b1;
      la_oe_b <= 1'b1;
      sa_oe_b <= 1'b1;
      sd_oe_b <= 1'b1;
    end else begin
      memr_b  <= ~(cmd_on & (cls == ISASEQ_MEM)  & ~wr);
      memw_b  <= ~(cmd_on & (cls == ISASEQ_MEM)  &  wr);
      smemr_b <= ~(cmd_on & (cls == ISASEQ_SMEM) & ~wr);
      smemw_b <= ~(cmd_on & (cls == ISASEQ_SMEM) &  wr);
      ior_b   <= ~(cmd_on & (cls == ISASEQ_IO)   & ~wr);
      iow_b   <= ~(cmd_on & (cls == ISASEQ_IO)   &  wr);
      la_oe_b <= (state == ISASEQ_IDLE);
      sa_oe_b <= (state == ISASEQ_IDLE);
      // write data driven for the whole access, released in idle
      sd_oe_b <= ~(wr & (state != ISASEQ_IDLE));
    end
  end

endmodule : isaseq_master

// >>> verif/isaseq_master_properties.sv
`timescale 1ns/1ns
module isaseq_master_properties (
  // clocks
  input wire logic         clk,
  input wire logic         rst_b,
  input wire logic         bus_clk,
  // bus side
  input wire logic         ale,
  input wire logic [23:17] la,
  input wire logic [19:0]  sa,
  input wire logic         memr_b,
  input wire logic         memw_b,
  input wire logic         smemr_b,
  input wire logic         smemw_b,
  input wire logic         ior_b,
  input wire logic         iow_b,
  input wire logic         rsp_valid
);
  logic [2:0] bc;
  logic [4:0] c_ale;
  logic [4:0] c_on;
  logic [4:0] c_off;
  logic [4:0] c_io;
  wire cmd = !(memr_b && memw_b && smemr_b && smemw_b && ior_b && iow_b);
  wire tick = bc[1] && !bc[2];
  wire io_cmd = !(ior_b && iow_b);

  function automatic logic [4:0] step(input logic ev, input logic tk,
                                      input logic [4:0] c);
    if (ev) return 5'h00;
    if (tk && c != 5'h1f) return c + 5'h01;
    return c;
  endfunction : step

  // same two-flop sampling as the design, so tick counts line up
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) bc <= 3'h0;
    else bc <= {bc[1:0], bus_clk};
  end

  // counts saturate high so nothing is judged before the first access
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      c_ale <= 5'h1f;
      c_on  <= 5'h1f;
      c_off <= 5'h1f;
      c_io  <= 5'h1f;
    end else begin
      c_io  <= step($rose(io_cmd), tick, c_io);
      c_ale <= step($rose(ale), tick, c_ale);
      c_on  <= step($rose(cmd), tick, c_on);
      c_off <= step($fell(cmd), tick, c_off);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_cmd_on;  $rose(cmd); endsequence
  sequence s_cmd_off; $fell(cmd); endsequence
  sequence s_strobe;  $rose(ale); endsequence

  a_strobe_to_cmd: assert property (s_cmd_on |-> c_ale >= 5'h02)
    else $error("command too soon after strobe");
  a_strobe_to_neg: assert property (s_cmd_off |-> c_ale >= 5'h0b)
    else $error("command negated too soon after strobe");
  a_cmd_width: assert property (s_cmd_off |-> c_on >= 5'h09)
    else $error("command too short");
  a_cmd_spacing: assert property (s_cmd_on |-> c_on >= 5'h0c)
    else $error("commands too close");
  a_neg_to_cmd: assert property (s_cmd_on |-> c_off >= 5'h03)
    else $error("command too soon after negation");
  a_cmd_to_strobe: assert property (s_strobe |-> c_on >= 5'h0a)
    else $error("strobe too soon after command");
  a_neg_to_strobe: assert property (s_strobe |-> c_off >= 5'h01)
    else $error("strobe too soon after negation");
  a_la_hold: assert property (c_on < 5'h0d |-> $stable(la))
    else $error("latched address changed early");
  a_sa_hold: assert property (c_on < 5'h0a |-> $stable(sa))
    else $error("system address changed early");
  // i/o commands need the longer system address hold
  a_io_sa_hold: assert property (c_io < 5'h13 |-> $stable(sa))
    else $error("system address changed early after i/o command");
  a_done_order: assert property (rsp_valid |-> ##[0:2] !cmd)
    else $error("done while command still low");
endmodule : isaseq_master_properties

bind isaseq_master isaseq_master_properties i_props (.clk, .rst_b,
  .bus_clk, .ale, .la, .sa, .memr_b, .memw_b, .smemr_b, .smemw_b,
  .ior_b, .iow_b, .rsp_valid);

// >>> verif/isaseq_slave_model.sv
`timescale 1ns/1ns
module isaseq_slave_model (
  // bus side
  input wire logic        bus_clk,
  input wire logic        memr_b,
  input wire logic        memw_b,
  input wire logic        smemr_b,
  input wire logic        smemw_b,
  input wire logic        ior_b,
  input wire logic        iow_b,
  input wire logic [19:0] sa,
  input wire logic [15:0] sd_out,
  // bench control: bus clocks of wait state
  input wire logic [4:0]  stall,
  output logic            iochrdy,
  output logic [15:0]     sd_in
);
  logic [15:0] mem [16];
  logic [15:0] last;
  logic [4:0]  left;
  wire rd = !(memr_b && smemr_b && ior_b);
  wire wr = !(memw_b && smemw_b && iow_b);

  initial begin
    left = 5'h00;
    last = 16'h0000;
  end
  // ready drops at command start, well inside the window
  always @(posedge rd or posedge wr) left = stall;
  always @(posedge bus_clk) if (left != 5'h00) left = left - 5'h01;
  assign iochrdy = (left == 5'h00);
  always @(negedge wr) mem[sa[3:0]] = sd_out;
  always @(negedge rd) last = mem[sa[3:0]];
  // released bus shows the inverse, never a stale match
  assign sd_in = rd ? mem[sa[3:0]] : ~last;
endmodule : isaseq_slave_model

// >>> verif/tb_isa_master_cycle_sequencer.sv
`timescale 1ns/1ns
module tb_isa_master_cycle_sequencer;
  import isaseq_pkg::*;
  logic clk, rst_b, bus_clk, req_valid, req_write, req_is16;
  isaseq_class_e req_class;
  logic [23:0] req_addr;
  logic [15:0] req_wdata, rsp_rdata, sd_out, sd_in;
  logic req_ready, rsp_valid, ale, la_oe_b, sa_oe_b, sd_oe_b, iochrdy;
  logic memr_b, memw_b, smemr_b, smemw_b, ior_b, iow_b;
  logic [23:17] la;
  logic [19:0] sa;
  logic [4:0] stall;
  int fails, checks;

  isaseq_master i_dut (.clk, .rst_b, .bus_clk, .req_valid, .req_write,
    .req_is16, .req_class, .req_addr, .req_wdata, .req_ready, .rsp_valid,
    .rsp_rdata, .ale, .la, .la_oe_b, .sa, .sa_oe_b, .memr_b, .memw_b,
    .smemr_b, .smemw_b, .ior_b, .iow_b, .sd_out, .sd_oe_b, .sd_in,
    .iochrdy);
  isaseq_slave_model i_slave (.bus_clk, .memr_b, .memw_b, .smemr_b,
    .smemw_b, .ior_b, .iow_b, .sa, .sd_out, .stall, .iochrdy, .sd_in);

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    bus_clk = 1'b0;
    #7;
    forever #80 bus_clk = ~bus_clk;
  end

  task automatic chk(input string n, input logic [15:0] e, g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask : chk

  function automatic logic [5:0] pins();
    return {memr_b, memw_b, smemr_b, smemw_b, ior_b, iow_b};
  endfunction : pins

  task automatic acc(input logic w, b16, input int cls, input int k,
                     output logic [15:0] q, output int low);
    int n;
    @(negedge clk);
    req_valid = 1'b1;
    req_write = w;
    req_is16 = b16;
    req_class = isaseq_class_e'(cls);
    req_addr = 24'h9a_bc00 | 24'(k << 1);
    req_wdata = 16'h5a00 + 16'(k);
    n = 0;
    while (req_ready !== 1'b1 && n < 4000) begin
      @(negedge clk);
      n++;
    end
    req_valid = 1'b0;
    while (&pins() === 1'b1 && n < 8000) begin
      @(negedge clk);
      n++;
    end
    chk("command pins", {10'h000, ~(6'h20 >> (cls * 2 + w))},
        {10'h000, pins()});
    chk("output enables", {13'h0000, 1'b0, 1'b0, !w},
        {13'h0000, la_oe_b, sa_oe_b, sd_oe_b});
    chk("system address", req_addr[15:0], sa[15:0]);
    chk("upper address", {9'h000, req_addr[23:17]}, {9'h000, la});
    low = 0;
    while (rsp_valid !== 1'b1 && n < 8000) begin
      @(negedge clk);
      n++;
      if (&pins() !== 1'b1) low++;
    end
    // a run-out of the wait limit must count, not leave stale data
    chk("access done", 16'h0001, {15'h0000, rsp_valid});
    q = rsp_rdata & (b16 ? 16'hffff : 16'h00ff);
  endtask : acc

  task automatic sc_classes;
    logic [15:0] q;
    int low;
    for (int k = 0; k < 6; k++) begin
      acc(1'b1, k[0], k >> 1, k, q, low);
      chk("write width", 16'h0001, {15'h0000, low >= 64});
      acc(1'b0, k[0], k >> 1, k, q, low);
      chk("read width", 16'h0001, {15'h0000, low >= 64});
      chk("read data", (16'h5a00 + 16'(k)) & (k[0] ? 16'hffff : 16'h00ff),
          q);
    end
  endtask : sc_classes

  task automatic sc_wait;
    logic [15:0] q;
    int low;
    stall = 5'h0e;
    acc(1'b0, 1'b0, 0, 4, q, low);
    chk("stretched 8-bit", 16'h0001, {15'h0000, low >= 104});
    acc(1'b0, 1'b1, 2, 5, q, low);
    chk("stretched 16-bit", 16'h0001, {15'h0000, low >= 104});
    chk("stretched data", 16'h5a05, q);
    stall = 5'h00;
  endtask : sc_wait

  task automatic sc_reset;
    logic [15:0] q;
    int low;
    stall = 5'h0e;
    @(negedge clk);
    req_valid = 1'b1;
    while (&pins() === 1'b1) @(negedge clk);
    rst_b = 1'b0;
    req_valid = 1'b0;
    stall = 5'h00;
    @(negedge clk);
    chk("pins in reset", 16'h003f, {10'h000, pins()});
    chk("strobe in reset", 16'h0000, {15'h0000, ale});
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    acc(1'b0, 1'b1, 0, 3, q, low);
    chk("data after reset", 16'h5a03, q);
  endtask : sc_reset

  task automatic end_of_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  initial begin
    fails = 0;
    checks = 0;
    rst_b = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_is16 = 1'b0;
    req_class = ISASEQ_MEM;
    req_addr = 24'h00_0000;
    req_wdata = 16'h0000;
    stall = 5'h00;
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    sc_classes();
    sc_wait();
    sc_reset();
    end_of_test();
  end

  // fifteen accesses of some 20 bus clocks fit well inside this
  initial begin
    #1_000_000;
    fails++;
    end_of_test();
  end
endmodule : tb_isa_master_cycle_sequencer
